// [key_edge_interrupt_map.svh]
// register offsets, field positions and reset values of the key interrupt block
`ifndef KEY_EDGE_INTERRUPT_MAP_SVH
`define KEY_EDGE_INTERRUPT_MAP_SVH

`define KEI_OFF_ENABLE    12'h000
`define KEI_OFF_FLAG      12'h004
`define KEI_OFF_LEVEL     12'h008
`define KEI_OFF_REDIRECT  12'h00c
`define KEI_OFF_STATUS    12'h010
`define KEI_OFF_MASK      12'h014

`define KEI_ENABLE_RESET  8'h00
`define KEI_FLAG_RESET    6'h00
`define KEI_REDIRECT_RESET 1'b0
`define KEI_MASK_RESET    2'h0

`define KEI_BASE_CH       4
`define KEI_FLAG_CH       6
`define KEI_ST_EDGE       0
`define KEI_ST_FLAGGED    1
`define KEI_HTRANS_NONSEQ 2'h2
`define KEI_HSIZE_WORD    3'h2

`endif

// [key_edge_interrupt_pkg.sv]
// types shared by the key interrupt block
package key_edge_interrupt_pkg;

    typedef struct packed {
        logic [7:0]  sync_a;
        logic [7:0]  sync_b;
        logic [7:0]  key_prev;
        logic [7:0]  key_enable_reg;
        logic [5:0]  key_flag_reg;
        logic        pin_redirect_reg;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic        key_irq;
        logic        dp_valid;
        logic        dp_write;
        logic [11:0] dp_addr;
        logic [31:0] hrdata;
    } state_t;

endpackage : key_edge_interrupt_pkg

// [key_edge_interrupt.sv]
// key edge interrupt block with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "key_edge_interrupt_map.svh"

// How it works
// - any edge on an enabled key channel with its pin present raises the shared key interrupt if its status bit is unmasked in irq_mask
// - eight enable bits, one per channel; only enabled channels contribute
// - event flags latch for channels zero to five only; six, seven have none
// - four channels by default, eight when redirection assigns the extra pins
module key_edge_interrupt #(
    parameter int CHANNELS = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  key_in,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             key_irq
);

    key_edge_interrupt_pkg::state_t cur;
    key_edge_interrupt_pkg::state_t next_cur;

    logic [7:0] pin_present;
    logic [7:0] edge_hit;
    logic [5:0] flag_set;
    logic [5:0] flag_keep;
    logic       any_edge;
    logic       wr_en;

    // channels four to seven exist only when redirected to pins
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            if (g < `KEI_BASE_CH) begin : g_base
                assign pin_present[g] = 1'b1;
            end else begin : g_extra
                assign pin_present[g] = cur.pin_redirect_reg;
            end
            assign edge_hit[g] = (cur.sync_b[g] ^ cur.key_prev[g])
                               & cur.key_enable_reg[g] & pin_present[g];
        end
    endgenerate

    assign any_edge = |edge_hit;
    assign flag_set = edge_hit[`KEI_FLAG_CH-1:0];
    assign wr_en    = cur.dp_valid & cur.dp_write;

    always_comb begin
        next_cur          = cur;
        flag_keep         = cur.key_flag_reg;
        next_cur.sync_a   = key_in;
        next_cur.sync_b   = cur.sync_a;
        next_cur.key_prev = cur.sync_b;

        // data phase write; the set below wins over a clear in the same cycle
        if (wr_en) begin
            if (cur.dp_addr == `KEI_OFF_ENABLE) begin
                next_cur.key_enable_reg = hwdata[7:0];
            end else if (cur.dp_addr == `KEI_OFF_FLAG) begin
                flag_keep = cur.key_flag_reg & hwdata[5:0];
            end else if (cur.dp_addr == `KEI_OFF_REDIRECT) begin
                next_cur.pin_redirect_reg = hwdata[0];
            end else if (cur.dp_addr == `KEI_OFF_STATUS) begin
                next_cur.irq_status = cur.irq_status & ~hwdata[1:0];
            end else if (cur.dp_addr == `KEI_OFF_MASK) begin
                next_cur.irq_mask = hwdata[1:0];
            end
        end
        next_cur.key_flag_reg = flag_keep | flag_set;
        next_cur.irq_status[`KEI_ST_EDGE]    = next_cur.irq_status[`KEI_ST_EDGE] | any_edge;
        next_cur.irq_status[`KEI_ST_FLAGGED] = next_cur.irq_status[`KEI_ST_FLAGGED]
                                             | (|flag_set);
        next_cur.key_irq = |(next_cur.irq_status & cur.irq_mask);

        // address phase capture; slave never stalls
        if (hready) begin
            next_cur.dp_valid = hsel & (htrans == `KEI_HTRANS_NONSEQ);
            next_cur.dp_write = hwrite;
            next_cur.dp_addr  = haddr[11:0];
            next_cur.hrdata   = 32'h0000_0000;
            if (hsel && htrans == `KEI_HTRANS_NONSEQ && !hwrite) begin
                if (haddr[11:0] == `KEI_OFF_ENABLE) begin
                    next_cur.hrdata[7:0] = cur.key_enable_reg;
                end else if (haddr[11:0] == `KEI_OFF_FLAG) begin
                    next_cur.hrdata[5:0] = cur.key_flag_reg;
                end else if (haddr[11:0] == `KEI_OFF_LEVEL) begin
                    next_cur.hrdata[7:0] = cur.sync_b & pin_present;
                end else if (haddr[11:0] == `KEI_OFF_REDIRECT) begin
                    next_cur.hrdata[0] = cur.pin_redirect_reg;
                end else if (haddr[11:0] == `KEI_OFF_STATUS) begin
                    next_cur.hrdata[1:0] = cur.irq_status;
                end else if (haddr[11:0] == `KEI_OFF_MASK) begin
                    next_cur.hrdata[1:0] = cur.irq_mask;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur                  <= '0;
            cur.key_enable_reg   <= `KEI_ENABLE_RESET;
            cur.key_flag_reg     <= `KEI_FLAG_RESET;
            cur.pin_redirect_reg <= `KEI_REDIRECT_RESET;
            cur.irq_mask         <= `KEI_MASK_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // zero wait states: the response registers are constant
    always_ff @(posedge clk_sys) begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end

    assign hrdata  = cur.hrdata;
    assign key_irq = cur.key_irq;

endmodule : key_edge_interrupt

`default_nettype wire

// [key_pins.sv]
// switch model driving the key pins
`timescale 1ns/1ps
`default_nettype none
module key_pins (
    input  wire logic       clk_sys,
    input  wire logic [7:0] level_cmd,
    output logic      [7:0] key_in
);
    // a switch settles one cycle after the bench moves it
    always_ff @(posedge clk_sys) key_in <= level_cmd;
endmodule : key_pins
`default_nettype wire

// [key_edge_interrupt_assertions.sv]
// port checks for the key interrupt block
`timescale 1ns/1ps
`default_nettype none
module key_edge_interrupt_assertions (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        key_irq,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hrdata
);
    logic        rd_v;
    logic [11:0] rd_a;
    // zero wait states, so the data phase is always the next cycle
    always_ff @(posedge clk_sys) begin
        rd_v <= !rst && hsel && htrans == 2'h2 && hready && !hwrite;
        rd_a <= haddr[11:0];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_irq_reset: assert property ($fell(rst) |-> !key_irq)
        else $error("irq high after reset");
    chk_enable_width: assert property (rd_v && rd_a == 12'h000 |-> hrdata[31:8] == 24'h0)
        else $error("enable upper bits set");
    chk_flag_width: assert property (rd_v && rd_a == 12'h004 |-> hrdata[31:6] == 26'h0)
        else $error("flag above channel five");
    chk_level_width: assert property (rd_v && rd_a == 12'h008 |-> hrdata[31:8] == 24'h0)
        else $error("level upper bits set");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready");
endmodule : key_edge_interrupt_assertions
bind key_edge_interrupt key_edge_interrupt_assertions u_key_edge_interrupt_assertions (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .key_irq(key_irq), .htrans(htrans),
    .haddr(haddr), .hrdata(hrdata));
`default_nettype wire

// [key_edge_interrupt_tb.sv]
// self-checking bench for the key interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module key_edge_interrupt_tb;
    logic        clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, key_irq;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  keys = 8'h00, key_in;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    int          err_total = 0, total_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    key_pins u_key_pins (.clk_sys(clk_sys), .level_cmd(keys), .key_in(key_in));
    key_edge_interrupt u_key_edge_interrupt (
        .clk_sys(clk_sys), .rst(rst), .key_in(key_in), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .key_irq(key_irq));
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= w;
        hsize  <= 3'h2;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK("read", e, rd)
    endtask : chk_rd
    // eight edges covers pin model, two sync flops, edge and irq stages
    task automatic kick(input logic [7:0] m);
        keys <= keys ^ m;
        repeat (8) @(posedge clk_sys);
    endtask : kick
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (2000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 6; i++) chk_rd(12'(4 * i), 32'h0);
        xfer(12'h000, 1'b1, 32'hff);
        xfer(12'h014, 1'b1, 32'h3);
        kick(8'h10);
        `CHK("irq", 1'b0, key_irq)
        kick(8'h01);
        `CHK("irq", 1'b1, key_irq)
        chk_rd(12'h004, 32'h01);
        xfer(12'h00c, 1'b1, 32'h1);
        kick(8'h20);
        chk_rd(12'h004, 32'h21);
        chk_rd(12'h008, 32'h31);
        kick(8'h80);
        chk_rd(12'h004, 32'h21);
        chk_rd(12'h010, 32'h3);
        xfer(12'h004, 1'b1, 32'h0);
        xfer(12'h010, 1'b1, 32'h3);
        xfer(12'h000, 1'b1, 32'hfe);
        kick(8'h01);
        `CHK("irq", 1'b0, key_irq)
        chk_rd(12'h004, 32'h0);
        chk_rd(12'h020, 32'h0);
        // masked events still latch status and flags
        xfer(12'h014, 1'b1, 32'h0);
        kick(8'h02);
        `CHK("irq", 1'b0, key_irq)
        chk_rd(12'h004, 32'h02);
        xfer(12'h004, 1'b1, 32'h02);
        chk_rd(12'h004, 32'h02);
        xfer(12'h014, 1'b1, 32'h3);
        kick(8'h00);
        `CHK("irq", 1'b1, key_irq)
        chk_rd(12'h010, 32'h3);
        complete_run();
    end
endmodule : key_edge_interrupt_tb
`default_nettype wire
